// ### design/cmo_pkg.sv
// constants shared by the clock monitor and oscillator step control
package cmo_pkg;

  // control register field positions
  localparam int unsigned CTL_EXT_STABLE_BIT = 0;
  localparam int unsigned CTL_EXT_ON_BIT = 1;
  localparam int unsigned CTL_INT_STABLE_BIT = 2;
  localparam int unsigned CTL_INT_ON_BIT = 3;
  localparam int unsigned CTL_SRC_SEL_BIT = 4;
  localparam int unsigned CTL_MON_ON_BIT = 5;
  localparam int unsigned CTL_MON_FLAG_BIT = 6;
  localparam int unsigned CTL_IRQ_EN_BIT = 7;
  localparam int unsigned CTL_W = 8;

  // values after reset: internal clock running and selected
  localparam logic RST_INT_ON = 1'b1;
  localparam logic RST_EXT_ON = 1'b0;
  localparam logic RST_SRC_SEL = 1'b0;
  localparam logic RST_MON_ON = 1'b0;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_MON_FLAG = 1'b0;

  // oscillator code layout
  localparam int unsigned STAGE_W = 8;
  localparam int unsigned DIV_W = 4;
  localparam int unsigned RING_SEL_LSB = 5;
  localparam logic [7:0] RST_STAGE_CODE = 8'h00;
  localparam logic [3:0] RST_DIV_CODE = 4'h0;
  localparam logic [3:0] DIV_CODE_MAX = 4'h9;
  localparam logic [7:0] FINE_STEP = 8'h01;
  localparam logic [7:0] COARSE_STEP = 8'h20;

  // ring length: base delays plus two per ring-select step
  localparam logic [4:0] RING_BASE_DELAYS = 5'h11;
  localparam int unsigned RING_DELAY_STEP_SHIFT = 1;

  // activity detector: missed reference low phases before inactive
  localparam logic [1:0] MISS_LIMIT = 2'h2;

endpackage

// ### design/cmo_act_det.sv
// clock activity detector: watches one clock against a slower reference
module cmo_act_det
  import cmo_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic watched_clk,
  input wire logic ref_clk,
  output logic inactive_q
);

  logic watched_prev_q; // last sample of the watched clock
  logic ref_prev_q; // last sample of the reference
  logic edge_seen_q; // a falling edge was seen in this low phase
  logic [1:0] miss_cnt_q; // consecutive low phases without an edge
  logic watched_fall;
  logic ref_rise;
  logic low_fall;

  assign watched_fall = watched_prev_q & ~watched_clk;
  assign ref_rise = ~ref_prev_q & ref_clk;
  // only edges during a reference low phase count
  assign low_fall = watched_fall & ~ref_clk;

  // sample both levels for edge detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      watched_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      watched_prev_q <= watched_clk;
      ref_prev_q <= ref_clk;
    end
  end

  // remember an edge until the low phase closes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      edge_seen_q <= 1'b0;
    end else if (!enable || ref_rise) begin
      edge_seen_q <= 1'b0;
    end else if (low_fall) begin
      edge_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      miss_cnt_q <= 2'h0;
      inactive_q <= 1'b0;
    end else if (!enable) begin
      // detector idle while either clock is off
      miss_cnt_q <= 2'h0;
      inactive_q <= 1'b0;
    end else if (low_fall) begin
      // any falling edge in a low phase revives the clock at once
      miss_cnt_q <= 2'h0;
      inactive_q <= 1'b0;
    end else if (ref_rise && !edge_seen_q) begin
      if (miss_cnt_q + 2'h1 >= MISS_LIMIT) begin
        inactive_q <= 1'b1;
        miss_cnt_q <= MISS_LIMIT;
      end else begin
        miss_cnt_q <= miss_cnt_q + 2'h1;
      end
    end else if (ref_rise) begin
      miss_cnt_q <= 2'h0;
    end
  end

endmodule

// ### design/cmo_clock_monitor.sv
// clock monitor supervision, forced source switching and oscillator step codes
module cmo_clock_monitor
  import cmo_pkg::*;
#(
  parameter int unsigned STAGE_BITS = STAGE_W,
  parameter int unsigned DIV_BITS = DIV_W
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ctl_wr,
  input wire logic [CTL_W-1:0] ctl_wdata,
  input wire logic ctl_rd,
  output logic [CTL_W-1:0] ctl_rdata_q,
  input wire logic internal_clock_ready,
  input wire logic external_clock_ready,
  input wire logic internal_clock,
  input wire logic external_clock,
  input wire logic internal_base_clock,
  input wire logic internal_ref_clock,
  input wire logic external_ref_clock,
  input wire logic loop_filter_up,
  input wire logic loop_filter_down,
  input wire logic loop_filter_coarse,
  output logic oscillator_output_clock,
  output logic timebase_clock,
  output logic clock_source_select,
  output logic monitor_flag,
  output logic monitor_irq,
  output logic internal_inactive,
  output logic external_inactive,
  output logic [STAGE_BITS-1:0] osc_stage_code_q,
  output logic [DIV_BITS-1:0] osc_divider_code_q,
  output logic [DIV_BITS-1:0] osc_divide_exponent,
  output logic [4:0] ring_stage_delays
);

  // software-held control bits
  logic internal_clock_on_q; // internal generator enabled
  logic external_clock_on_q; // external generator enabled
  logic src_sel_q; // 1 selects the external clock
  logic clock_monitor_on_q; // monitor armed
  logic monitor_irq_enable_q; // interrupt gate
  logic monitor_flag_q; // sticky monitor event
  logic flag_read_q; // flag was read while set
  logic any_inactive_q; // last value of combined inactivity

  // derived status
  logic internal_clock_stable; // reported stable, gated as hardware does
  logic external_clock_stable;
  logic all_ready; // both on and both stable
  logic any_inactive;
  logic inactive_rise;
  logic det_enable;
  logic force_ext; // monitor forces external after internal died
  logic force_int; // monitor forces internal after external died
  logic tb_sel_ext; // timebase switch select
  logic out_sel_ext; // output clock switch select

  // stability reads clear while a clock is off or judged inactive
  assign internal_clock_stable = internal_clock_ready & internal_clock_on_q & ~internal_inactive;
  assign external_clock_stable = external_clock_ready & external_clock_on_q & ~external_inactive;
  assign all_ready = internal_clock_on_q & external_clock_on_q
                   & internal_clock_stable & external_clock_stable;

  // detectors run only while both clocks run, else nothing to compare
  assign det_enable = internal_clock_on_q & external_clock_on_q;

  // internal base clock judged against external reference
  cmo_act_det u_int_det (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(det_enable),
    .watched_clk(internal_base_clock),
    .ref_clk(external_ref_clock),
    .inactive_q(internal_inactive)
  );

  // external clock judged against internal reference
  cmo_act_det u_ext_det (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(det_enable),
    .watched_clk(external_clock),
    .ref_clk(internal_ref_clock),
    .inactive_q(external_inactive)
  );

  assign any_inactive = internal_inactive | external_inactive;
  assign inactive_rise = any_inactive & ~any_inactive_q;

  // forced choices only act while the monitor is on
  assign force_ext = clock_monitor_on_q & internal_inactive & ~external_inactive;
  assign force_int = clock_monitor_on_q & external_inactive & ~internal_inactive;

  // edge history of combined inactivity
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      any_inactive_q <= 1'b0;
    end else begin
      any_inactive_q <= any_inactive;
    end
  end

  // generator enable bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      internal_clock_on_q <= RST_INT_ON;
      external_clock_on_q <= RST_EXT_ON;
    end else if (ctl_wr) begin
      // the running clock cannot be turned off
      if (ctl_wdata[CTL_INT_ON_BIT] || !src_sel_q) begin
        internal_clock_on_q <= ctl_wdata[CTL_INT_ON_BIT] | ~src_sel_q;
      end else begin
        internal_clock_on_q <= 1'b0;
      end
      if (ctl_wdata[CTL_EXT_ON_BIT] || src_sel_q) begin
        external_clock_on_q <= ctl_wdata[CTL_EXT_ON_BIT] | src_sel_q;
      end else begin
        external_clock_on_q <= 1'b0;
      end
    end
  end

  // source select: software write, or forced by the monitor
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      src_sel_q <= RST_SRC_SEL;
    end else if (force_ext) begin
      src_sel_q <= 1'b1;
    end else if (force_int) begin
      src_sel_q <= 1'b0;
    end else if (ctl_wr && ctl_wdata[CTL_SRC_SEL_BIT] != src_sel_q) begin
      // switch needs both on, target stable
      if (internal_clock_on_q && external_clock_on_q) begin
        if (ctl_wdata[CTL_SRC_SEL_BIT] ? external_clock_stable : internal_clock_stable) begin
          src_sel_q <= ctl_wdata[CTL_SRC_SEL_BIT];
        end
      end
    end
  end

  // monitor enable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clock_monitor_on_q <= RST_MON_ON;
    end else if (ctl_wr) begin
      if (!ctl_wdata[CTL_MON_ON_BIT]) begin
        // clearing is always allowed, the service routine relies on it
        clock_monitor_on_q <= 1'b0;
      end else if (all_ready) begin
        clock_monitor_on_q <= 1'b1;
      end
    end
  end

  // interrupt enable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      monitor_irq_enable_q <= RST_IRQ_EN;
    end else if (ctl_wr) begin
      // needs monitor on before write
      // a full mask written once may need a second write for this bit
      monitor_irq_enable_q <= ctl_wdata[CTL_IRQ_EN_BIT] & clock_monitor_on_q;
    end
  end

  // read arming for the flag clear sequence
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_read_q <= 1'b0;
    end else if (ctl_wr) begin
      // any write ends the sequence, a fresh read is needed next time
      flag_read_q <= 1'b0;
    end else if (ctl_rd && monitor_flag_q) begin
      flag_read_q <= 1'b1;
    end
  end

  // sticky monitor flag
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      monitor_flag_q <= RST_MON_FLAG;
    end else if (clock_monitor_on_q && inactive_rise) begin
      // set on new inactivity
      // set wins over a clear in the same cycle
      monitor_flag_q <= 1'b1;
    end else if (ctl_wr && flag_read_q && !ctl_wdata[CTL_MON_FLAG_BIT]) begin
      // read then write zero
      // writing one leaves the flag as it is
      monitor_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_rdata_q <= '0;
    end else begin
      ctl_rdata_q <= '0;
      ctl_rdata_q[CTL_EXT_STABLE_BIT] <= external_clock_stable;
      ctl_rdata_q[CTL_EXT_ON_BIT] <= external_clock_on_q;
      ctl_rdata_q[CTL_INT_STABLE_BIT] <= internal_clock_stable;
      ctl_rdata_q[CTL_INT_ON_BIT] <= internal_clock_on_q;
      ctl_rdata_q[CTL_SRC_SEL_BIT] <= src_sel_q;
      ctl_rdata_q[CTL_MON_ON_BIT] <= clock_monitor_on_q;
      ctl_rdata_q[CTL_MON_FLAG_BIT] <= monitor_flag_q;
      ctl_rdata_q[CTL_IRQ_EN_BIT] <= monitor_irq_enable_q;
    end
  end

  assign monitor_irq = monitor_flag_q & monitor_irq_enable_q;
  assign monitor_flag = monitor_flag_q;
  assign clock_source_select = src_sel_q;

  // survivor drives both clocks
  // timebase follows the external enable unless the monitor overrides
  assign tb_sel_ext = force_ext | (external_clock_on_q & ~force_int);
  assign out_sel_ext = src_sel_q;

  // reset forces internal clock
  // plain mux, the glitch-free synchroniser lives in the clock switch cell
  assign oscillator_output_clock = (resetn & out_sel_ext) ? external_clock : internal_clock;
  assign timebase_clock = (resetn & tb_sel_ext) ? external_clock : internal_clock;

  // oscillator step logic
  logic [STAGE_BITS-1:0] step; // size of one correction
  logic [STAGE_BITS:0] stage_sum; // stage plus step, carry on top
  logic [STAGE_BITS:0] stage_diff; // stage minus step, borrow on top
  logic div_at_max;
  logic div_at_min;

  assign step = loop_filter_coarse ? STAGE_BITS'(COARSE_STEP) : STAGE_BITS'(FINE_STEP);
  assign stage_sum = {1'b0, osc_stage_code_q} + {1'b0, step};
  assign stage_diff = {1'b0, osc_stage_code_q} - {1'b0, step};
  // codes above the limit already act as the limit
  assign div_at_max = osc_divider_code_q >= DIV_BITS'(DIV_CODE_MAX);
  assign div_at_min = osc_divider_code_q == '0;

  // codes step only by loop filter corrections
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      osc_stage_code_q <= STAGE_BITS'(RST_STAGE_CODE);
      osc_divider_code_q <= DIV_BITS'(RST_DIV_CODE);
    end else if (loop_filter_up && !loop_filter_down) begin
      if (stage_sum[STAGE_BITS]) begin
        // longest period reached: hold rather than wrap to short
        if (!div_at_max) begin
          osc_stage_code_q <= stage_sum[STAGE_BITS-1:0];
          osc_divider_code_q <= osc_divider_code_q + DIV_BITS'(1);
        end
      end else begin
        osc_stage_code_q <= stage_sum[STAGE_BITS-1:0];
      end
    end else if (loop_filter_down && !loop_filter_up) begin
      if (stage_diff[STAGE_BITS]) begin
        // shortest period reached: hold rather than wrap to long
        if (!div_at_min) begin
          osc_stage_code_q <= stage_diff[STAGE_BITS-1:0];
          osc_divider_code_q <= osc_divider_code_q - DIV_BITS'(1);
        end
      end else begin
        osc_stage_code_q <= stage_diff[STAGE_BITS-1:0];
      end
    end
  end

  assign osc_divide_exponent = div_at_max ? DIV_BITS'(DIV_CODE_MAX) : osc_divider_code_q;

  assign ring_stage_delays = RING_BASE_DELAYS
    + 5'({2'b00, osc_stage_code_q[STAGE_BITS-1:RING_SEL_LSB]} << RING_DELAY_STEP_SHIFT);

endmodule

// ### tb/cmo_clock_monitor_properties.sv
// port-level checker for the clock monitor and oscillator step control
module cmo_clock_monitor_properties
  import cmo_pkg::*;
#(
  parameter int unsigned STAGE_BITS = STAGE_W,
  parameter int unsigned DIV_BITS = DIV_W
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ctl_wr,
  input wire logic [CTL_W-1:0] ctl_wdata,
  input wire logic [CTL_W-1:0] ctl_rdata_q,
  input wire logic internal_clock_ready,
  input wire logic external_clock_ready,
  input wire logic internal_clock,
  input wire logic external_clock,
  input wire logic loop_filter_up,
  input wire logic loop_filter_down,
  input wire logic loop_filter_coarse,
  input wire logic oscillator_output_clock,
  input wire logic clock_source_select,
  input wire logic monitor_flag,
  input wire logic internal_inactive,
  input wire logic external_inactive,
  input wire logic [STAGE_BITS-1:0] osc_stage_code_q,
  input wire logic [DIV_BITS-1:0] osc_divider_code_q,
  input wire logic [4:0] ring_stage_delays
);
  // one clock domain, so clock and reset are stated once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // the image lags state by one edge, hence depth two back to the write
  property p_mon_on_gate;
    $rose(ctl_rdata_q[5]) |-> $past(ctl_wr, 2) && $past(ctl_wdata[5], 2)
      && $past(internal_clock_ready, 2) && $past(external_clock_ready, 2);
  endproperty
  a_mon_on_gate: assert property (p_mon_on_gate)
    else $error("monitor enabled without both clocks ready");
  property p_irq_en_gate;
    $rose(ctl_rdata_q[7]) |-> $past(ctl_rdata_q[5]);
  endproperty
  a_irq_en_gate: assert property (p_irq_en_gate)
    else $error("irq enable set before monitor was on");
  property p_flag_bit_six;
    ctl_rdata_q[6] == $past(monitor_flag);
  endproperty
  a_flag_bit_six: assert property (p_flag_bit_six)
    else $error("flag not shown at bit six");
  property p_flag_clear;
    $fell(monitor_flag) |-> $past(ctl_wr) && !$past(ctl_wdata[6]);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag fell without a zero write");
  property p_mon_on_sticky;
    $fell(ctl_rdata_q[5]) |-> $past(ctl_wr, 2) && !$past(ctl_wdata[5], 2);
  endproperty
  a_mon_on_sticky: assert property (p_mon_on_sticky)
    else $error("monitor on dropped without a write");
  property p_force_ext;
    internal_inactive && !external_inactive && ctl_rdata_q[5] && !$past(ctl_wr)
      |=> clock_source_select;
  endproperty
  a_force_ext: assert property (p_force_ext)
    else $error("no forced switch to the external clock");
  property p_force_int;
    external_inactive && !internal_inactive && ctl_rdata_q[5] && !$past(ctl_wr)
      |=> !clock_source_select;
  endproperty
  a_force_int: assert property (p_force_int)
    else $error("no forced switch to the internal clock");
  property p_out_mux;
    oscillator_output_clock == (clock_source_select ? external_clock : internal_clock);
  endproperty
  a_out_mux: assert property (p_out_mux)
    else $error("output clock not from selected source");
  property p_div_cause;
    osc_divider_code_q != $past(osc_divider_code_q)
      |-> $past(loop_filter_up) != $past(loop_filter_down);
  endproperty
  a_div_cause: assert property (p_div_cause)
    else $error("divider moved without a correction");
  property p_fine_carry;
    loop_filter_up && !loop_filter_down && !loop_filter_coarse && osc_stage_code_q == 8'hFF
      && osc_divider_code_q < 4'h9 |=> osc_stage_code_q == 8'h00
      && osc_divider_code_q == $past(osc_divider_code_q) + 4'h1;
  endproperty
  a_fine_carry: assert property (p_fine_carry)
    else $error("stage carry did not step divider");
  property p_coarse_step;
    loop_filter_coarse && loop_filter_up && !loop_filter_down && osc_stage_code_q < 8'hE0
      |=> osc_stage_code_q == $past(osc_stage_code_q) + 8'h20 && $stable(osc_divider_code_q);
  endproperty
  a_coarse_step: assert property (p_coarse_step)
    else $error("coarse step not one ring step");
  property p_ring_len;
    ring_stage_delays == 5'h11 + {1'b0, osc_stage_code_q[7:5], 1'b0};
  endproperty
  a_ring_len: assert property (p_ring_len)
    else $error("ring length wrong");
endmodule

// ### tb/cmo_clock_monitor_tb_top.sv
// self-checking bench for the clock monitor and oscillator step control
module cmo_clock_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, resetn = 1'b0, ctl_wr = 1'b0, ctl_rd = 1'b0;
  logic [7:0] ctl_wdata = 8'h00;
  logic internal_clock_ready = 1'b1, external_clock_ready = 1'b1;
  logic internal_clock = 1'b0, external_clock = 1'b0, internal_base_clock = 1'b0;
  logic internal_ref_clock = 1'b0, external_ref_clock = 1'b0;
  logic loop_filter_up = 1'b0, loop_filter_down = 1'b0, loop_filter_coarse = 1'b0;
  logic [7:0] ctl_rdata_q, osc_stage_code_q;
  logic oscillator_output_clock, timebase_clock, clock_source_select;
  logic monitor_flag, monitor_irq, internal_inactive, external_inactive;
  logic [3:0] osc_divider_code_q, osc_divide_exponent;
  logic [4:0] ring_stage_delays;
  logic [4:0] cnt = 5'h00; // phase counter for the clock levels
  logic kill_int = 1'b0; // stops the internal base clock
  logic kill_ext = 1'b0; // stops the external clock
  int miscompares = 0;
  int comparisons = 0;

  cmo_clock_monitor dut (.core_clk, .resetn, .ctl_wr, .ctl_wdata, .ctl_rd, .ctl_rdata_q,
    .internal_clock_ready, .external_clock_ready, .internal_clock, .external_clock,
    .internal_base_clock, .internal_ref_clock, .external_ref_clock, .loop_filter_up,
    .loop_filter_down, .loop_filter_coarse, .oscillator_output_clock, .timebase_clock,
    .clock_source_select, .monitor_flag, .monitor_irq, .internal_inactive, .external_inactive,
    .osc_stage_code_q, .osc_divider_code_q, .osc_divide_exponent, .ring_stage_delays);

  // 50 MHz core clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // fast external clock assumed
  // references run at an eighth of the watched clocks, well under half as required
  always @(posedge core_clk) begin
    cnt <= cnt + 5'h01;
    internal_clock <= cnt[0];
    external_clock <= cnt[1] & ~kill_ext;
    internal_base_clock <= cnt[1] & ~kill_int;
    internal_ref_clock <= cnt[4];
    external_ref_clock <= cnt[4];
  end

  // compare and count; unknowns never match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one-cycle pulses, each request launched and dropped on rising edges
  task automatic wr(input logic [7:0] v);
    @(posedge core_clk);
    ctl_wr <= 1'b1;
    ctl_wdata <= v;
    @(posedge core_clk);
    ctl_wr <= 1'b0;
  endtask
  task automatic rd;
    @(posedge core_clk);
    ctl_rd <= 1'b1;
    @(posedge core_clk);
    ctl_rd <= 1'b0;
  endtask
  task automatic step(input logic up, input logic dn, input logic crs);
    @(posedge core_clk);
    {loop_filter_up, loop_filter_down, loop_filter_coarse} <= {up, dn, crs};
    @(posedge core_clk);
    {loop_filter_up, loop_filter_down, loop_filter_coarse} <= 3'h0;
  endtask
  // the register image trails state by one edge
  task automatic settle;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic wchk(input logic [7:0] v, input logic [7:0] exp, input string what);
    wr(v);
    settle();
    chk({8'h00, ctl_rdata_q}, {8'h00, exp}, what);
  endtask
  task automatic codes(input logic [15:0] exp, input string what);
    settle();
    chk({4'h0, osc_divider_code_q, osc_stage_code_q}, exp, what);
  endtask

  // reset image: internal clock on, stable and selected
  task automatic t_reset;
    settle();
    chk({8'h00, ctl_rdata_q}, 16'h000C, "reset image");
    chk({15'h0000, oscillator_output_clock ^ internal_clock}, 16'h0000, "reset clock");
  endtask
  // full mask needs three writes: external on, then monitor, then irq
  task automatic t_enable;
    wchk(8'hAF, 8'h0F, "first mask write");
    wchk(8'hAF, 8'h2F, "second mask write");
    wchk(8'hAF, 8'hAF, "third mask write");
    @(posedge core_clk);
    external_clock_ready <= 1'b0;
    settle();
    chk({8'h00, ctl_rdata_q}, 16'h00AE, "monitor holds unstable");
    @(posedge core_clk);
    external_clock_ready <= 1'b1;
  endtask
  // internal base clock dies: forced switch, flag, irq, then the clear sequence
  task automatic t_fail;
    int n;
    @(posedge core_clk);
    kill_int <= 1'b1;
    for (n = 0; n < 300 && internal_inactive !== 1'b1; n++) @(negedge core_clk);
    chk({15'h0000, internal_inactive}, 16'h0001, "inactivity seen");
    settle();
    chk({8'h00, ctl_rdata_q}, 16'h00FB, "forced switch image");
    chk({14'h0000, monitor_irq, monitor_flag}, 16'h0003, "flag and irq");
    chk({15'h0000, oscillator_output_clock ^ external_clock}, 16'h0000, "output clock");
    chk({15'h0000, timebase_clock ^ external_clock}, 16'h0000, "timebase clock");
    wchk(8'hBB, 8'hFB, "unarmed zero write");
    rd();
    wchk(8'hFB, 8'hFB, "one write keeps flag");
    rd();
    wchk(8'hBB, 8'hBB, "read then zero clears");
    chk({15'h0000, monitor_irq}, 16'h0000, "irq drops");
    wchk(8'h1B, 8'h1B, "service turns monitor off");
    @(posedge core_clk);
    kill_int <= 1'b0;
  endtask
  // stage and divider stepping, carries, borrows and the divider ceiling
  task automatic t_osc;
    int k;
    step(1'b0, 1'b1, 1'b0);
    codes(16'h0000, "borrow at floor");
    for (k = 0; k < 8; k++) begin
      chk({11'h000, ring_stage_delays}, 16'(17 + 2 * k), "ring length");
      step(1'b1, 1'b0, 1'b1);
      settle();
    end
    codes(16'h0100, "coarse carry");
    step(1'b0, 1'b1, 1'b0);
    codes(16'h00FF, "fine borrow");
    step(1'b1, 1'b0, 1'b0);
    codes(16'h0100, "fine carry");
    step(1'b1, 1'b1, 1'b0);
    codes(16'h0100, "opposed pulses");
    for (k = 0; k < 71; k++) step(1'b1, 1'b0, 1'b1);
    codes(16'h09E0, "divider ceiling");
    chk({12'h000, osc_divide_exponent}, 16'h0009, "exponent ceiling");
    step(1'b1, 1'b0, 1'b1);
    codes(16'h09E0, "carry refused at ceiling");
  endtask
  // external clock dies while selected: forced back to internal, flag set
  task automatic t_ext_fail;
    int n;
    wchk(8'h3F, 8'h3F, "monitor on, external selected");
    @(posedge core_clk);
    kill_ext <= 1'b1;
    for (n = 0; n < 300 && external_inactive !== 1'b1; n++) @(negedge core_clk);
    chk({15'h0000, external_inactive}, 16'h0001, "external inactivity seen");
    settle();
    chk({8'h00, ctl_rdata_q}, 16'h006E, "forced back to internal");
    chk({14'h0000, monitor_irq, monitor_flag}, 16'h0001, "flag without irq");
    chk({15'h0000, oscillator_output_clock ^ internal_clock}, 16'h0000, "output internal");
    chk({15'h0000, timebase_clock ^ internal_clock}, 16'h0000, "timebase internal");
    rd();
    wchk(8'h2A, 8'h2E, "flag cleared after loss");
    wchk(8'h0A, 8'h0E, "monitor off after loss");
    @(posedge core_clk);
    kill_ext <= 1'b0;
  endtask

  // verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_enable();
    t_fail();
    t_osc();
    t_ext_fail();
    stop_test();
  end
  // the run needs about four hundred cycles; five thousand means a hang
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule

bind cmo_clock_monitor cmo_clock_monitor_properties #(.STAGE_BITS(STAGE_BITS),
  .DIV_BITS(DIV_BITS)) u_props (.core_clk, .resetn, .ctl_wr, .ctl_wdata, .ctl_rdata_q,
  .internal_clock_ready, .external_clock_ready, .internal_clock, .external_clock,
  .loop_filter_up, .loop_filter_down, .loop_filter_coarse, .oscillator_output_clock,
  .clock_source_select, .monitor_flag, .internal_inactive, .external_inactive,
  .osc_stage_code_q, .osc_divider_code_q, .ring_stage_delays);
